// File: hdl/abs_ctrl.sv
// boundary-scan capture, shift and update cells for the converter analog core
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module abs_ctrl (
   input wire logic i_core_clk,
   input wire logic i_rst,
   // scan controls from the test access port logic on this clock
   input wire logic i_capture_dr,
   input wire logic i_shift_dr,
   input wire logic i_update_dr,
   input wire logic i_tdi,
   output logic o_tdo,
   // comparator output from the analog core
   input wire logic i_comparator_out,
   // register port
   input wire logic [abs_pkg::ABS_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rd_data,
   // analog controls
   output logic o_sample_hold,
   output logic o_comparator_precharge_n,
   output logic o_neg_input_ground_enable,
   output logic [abs_pkg::NEG_SEL_W-1:0] o_neg_input_select,
   output logic o_gain_pass_gate_enable,
   output logic o_supply_reference_select,
   output logic o_settle_assist,
   output logic [abs_pkg::DAC_W-1:0] o_dac_code,
   output logic o_converter_power_enable,
   output logic o_gain_stage_power_enable,
   output logic [abs_pkg::MUX_W-1:0] o_input_mux_select,
   output logic o_bandgap_as_dac_reference,
   output logic o_bandgap_neg_enable,
   output logic o_gain_ten_enable,
   output logic o_gain_twenty_enable,
   output logic o_switch_cap_test_enable,
   output logic o_comparator_high_speed,
   output logic o_gain_clock,
   output logic o_gain_path_enable,
   output logic o_bypass_channels
);
   import abs_pkg::*;

   logic [ABS_CHAIN_LEN-1:0] shift_reg;
   logic [ABS_CHAIN_LEN-1:0] upd_reg;
   logic comp_sync;
   logic scan_en;
   logic contention;
   logic upd_fire;

   abs_sync u_comp_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_comparator_out),
      .o_sync(comp_sync)
   );

   // flags when more than one negative-input source is selected at once
   function automatic logic multi_source(input logic [ABS_CHAIN_LEN-1:0] v);
      logic [1:0] n;
      n = 2'(v[POS_GND_EN]) + 2'(v[POS_BG_NEG]) + 2'(|v[POS_NEG_SEL +: NEG_SEL_W]);
      return n > 2'd1;
   endfunction : multi_source

   assign upd_fire = i_update_dr && scan_en;
   assign contention = multi_source(upd_reg);

   // capture takes priority over shift; comparator result lands in its cell
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_reg <= ABS_IDLE;
      end else if (i_capture_dr) begin
         shift_reg <= upd_reg;
         shift_reg[POS_COMP] <= comp_sync;
      end else if (i_shift_dr) begin
         shift_reg <= {i_tdi, shift_reg[ABS_CHAIN_LEN-1:1]};
      end
   end

   assign o_tdo = shift_reg[0];

   // update stage starts at idle values and moves only on an update
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         upd_reg <= ABS_IDLE;
      end else if (upd_fire) begin
         upd_reg <= shift_reg;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         scan_en <= CTRL_SCAN_EN_RST;
      end else if (i_wr && i_addr == ADDR_CTRL) begin
         scan_en <= i_wr_data[CTRL_SCAN_EN];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            ADDR_UPD_LO: o_rd_data <= upd_reg[31:0];
            ADDR_UPD_HI: o_rd_data <= {25'h000_0000, upd_reg[ABS_CHAIN_LEN-1:32]};
            ADDR_CTRL: o_rd_data <= {31'h0000_0000, scan_en};
            ADDR_STATUS: o_rd_data <= {30'h0000_0000, contention, comp_sync};
            default: o_rd_data <= 32'h0000_0000;
         endcase
      end else begin
         o_rd_data <= 32'h0000_0000;
      end
   end

   // analog controls are straight taps of the update stage
   assign o_sample_hold = upd_reg[POS_HOLD];
   assign o_comparator_precharge_n = upd_reg[POS_COMPARATOR_PRECHARGE_N_N];
   assign o_neg_input_ground_enable = upd_reg[POS_GND_EN];
   assign o_neg_input_select = upd_reg[POS_NEG_SEL +: NEG_SEL_W];
   assign o_gain_pass_gate_enable = upd_reg[POS_PASS_GATE];
   assign o_supply_reference_select = upd_reg[POS_SUPPLY_REF];
   assign o_settle_assist = upd_reg[POS_SETTLE];
   assign o_dac_code = upd_reg[POS_DAC +: DAC_W];
   assign o_converter_power_enable = upd_reg[POS_CONV_PWR];
   assign o_gain_stage_power_enable = upd_reg[POS_GAIN_PWR];
   assign o_input_mux_select = upd_reg[POS_MUX +: MUX_W];
   assign o_bandgap_as_dac_reference = upd_reg[POS_BG_REF];
   assign o_bandgap_neg_enable = upd_reg[POS_BG_NEG];
   assign o_gain_ten_enable = upd_reg[POS_GAIN_TEN];
   assign o_gain_twenty_enable = upd_reg[POS_GAIN_TWENTY];
   assign o_switch_cap_test_enable = upd_reg[POS_SC_TEST];
   assign o_comparator_high_speed = upd_reg[POS_HIGH_SPEED];
   assign o_gain_clock = upd_reg[POS_GAIN_CLK];
   assign o_gain_path_enable = upd_reg[POS_GAIN_PATH];
   assign o_bypass_channels = upd_reg[POS_BYPASS];

   // assertions
   sequence s_update;
      upd_fire;
   endsequence

   property p_hold_follows;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_sample_hold == $past(shift_reg[POS_HOLD]);
   endproperty
   a_hold_follows: assert property (p_hold_follows)
      else $error("hold control did not follow update");

   property p_comparator_precharge_n;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_comparator_precharge_n == $past(shift_reg[POS_COMPARATOR_PRECHARGE_N_N]);
   endproperty
   a_comparator_precharge_n: assert property (p_comparator_precharge_n)
      else $error("precharge control did not follow update");

   property p_gnd;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_neg_input_ground_enable == $past(shift_reg[POS_GND_EN]);
   endproperty
   a_gnd: assert property (p_gnd)
      else $error("ground enable wrong after update");

   property p_neg_input_select;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_neg_input_select == $past(shift_reg[POS_NEG_SEL +: NEG_SEL_W]);
   endproperty
   a_neg_input_select: assert property (p_neg_input_select)
      else $error("negative select wrong after update");

   property p_pass;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_gain_pass_gate_enable == $past(shift_reg[POS_PASS_GATE]);
   endproperty
   a_pass: assert property (p_pass)
      else $error("pass gate wrong after update");

   property p_vref;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_supply_reference_select == $past(shift_reg[POS_SUPPLY_REF]);
   endproperty
   a_vref: assert property (p_vref)
      else $error("supply reference wrong after update");

   property p_dac;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_dac_code == $past(shift_reg[POS_DAC +: DAC_W]);
   endproperty
   a_dac: assert property (p_dac)
      else $error("dac code wrong after update");

   property p_pwr;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_converter_power_enable == $past(shift_reg[POS_CONV_PWR]);
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("power enable wrong after update");

   property p_mux;
      @(posedge i_core_clk) disable iff (i_rst)
      s_update |=> o_input_mux_select == $past(shift_reg[POS_MUX +: MUX_W]);
   endproperty
   a_mux: assert property (p_mux)
      else $error("input mux select wrong after update");

   property p_capture;
      @(posedge i_core_clk) disable iff (i_rst)
      i_capture_dr |=> shift_reg[POS_COMP] == $past(comp_sync);
   endproperty
   a_capture: assert property (p_capture)
      else $error("comparator result not captured");

   property p_stable;
      @(posedge i_core_clk) disable iff (i_rst)
      !upd_fire |=> $stable(upd_reg) && $stable(o_dac_code);
   endproperty
   a_stable: assert property (p_stable)
      else $error("controls changed without update");

   property p_idle;
      @(posedge i_core_clk)
      $fell(i_rst) |-> upd_reg == ABS_IDLE && o_sample_hold && o_comparator_precharge_n;
   endproperty
   a_idle: assert property (p_idle)
      else $error("controls not idle after reset");
endmodule : abs_ctrl

// File: hdl/abs_pkg.sv
// constants for the converter boundary-scan control cells
// Summary of operation
// - hold low tracks input, high freezes sample
// - precharge comparator latch while precharge control low
// - ground enable grounds comparator negative input
// - three-bit field selects differential negative input
// - pass-gate control enables gain pass gate, idles 1
// - supply select makes supply the converter reference
// - ten-bit code drives the internal DAC
// - power control powers converter analog circuitry
// - comparator result captured into observable scan cell
package abs_pkg;
   localparam int ABS_CHAIN_LEN = 39;
   localparam int ABS_ADDR_W = 8;
   // chain positions, bit 0 is first in and first out
   localparam int POS_SUPPLY_REF = 0;
   localparam int POS_SETTLE = 1;
   localparam int POS_COMPARATOR_PRECHARGE_N_N = 2;
   localparam int POS_PASS_GATE = 3;
   localparam int POS_NEG_SEL = 4;
   localparam int NEG_SEL_W = 3;
   localparam int POS_MUX = 7;
   localparam int MUX_W = 8;
   localparam int POS_BG_REF = 15;
   localparam int POS_HOLD = 16;
   localparam int POS_GND_EN = 17;
   localparam int POS_BYPASS = 18;
   localparam int POS_DAC = 19;
   localparam int DAC_W = 10;
   localparam int POS_GAIN_PWR = 29;
   localparam int POS_CONV_PWR = 30;
   localparam int POS_BG_NEG = 31;
   localparam int POS_HIGH_SPEED = 32;
   localparam int POS_GAIN_PATH = 33;
   localparam int POS_GAIN_CLK = 34;
   localparam int POS_COMP = 35;
   localparam int POS_GAIN_TEN = 36;
   localparam int POS_GAIN_TWENTY = 37;
   localparam int POS_SC_TEST = 38;
   // idle values: hold, mux bit 0, pass gate, precharge, dac bit 9, bypass high
   localparam logic [ABS_CHAIN_LEN-1:0] ABS_IDLE = 39'h00_1005_008C;
   // register port map
   localparam logic [ABS_ADDR_W-1:0] ADDR_UPD_LO = 8'h00;
   localparam logic [ABS_ADDR_W-1:0] ADDR_UPD_HI = 8'h04;
   localparam logic [ABS_ADDR_W-1:0] ADDR_CTRL = 8'h08;
   localparam logic [ABS_ADDR_W-1:0] ADDR_STATUS = 8'h0C;
   localparam int CTRL_SCAN_EN = 0;
   localparam logic CTRL_SCAN_EN_RST = 1'b1;
   localparam int STAT_COMP = 0;
   localparam int STAT_CONTENTION = 1;
endpackage : abs_pkg

// File: hdl/abs_sync.sv
// two-flop synchroniser for the analog comparator result
`timescale 1ns/10ps
module abs_sync (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : abs_sync

// File: verif/abs_tester.sv
// tester model that loads the converter scan cells and reads them back
`timescale 1ns/10ps
module abs_tester (
   input wire logic i_core_clk,
   input wire logic i_tdo,
   output logic o_capture_dr,
   output logic o_shift_dr,
   output logic o_update_dr,
   output logic o_tdi
);
   import abs_pkg::*;
   initial begin
      o_capture_dr = 1'b0;
      o_shift_dr = 1'b0;
      o_update_dr = 1'b0;
      o_tdi = 1'b0;
   end
   // gain ten and twenty, gain path and clock, settle assist and high speed stay idle
   function automatic logic [ABS_CHAIN_LEN-1:0] legal(input logic [ABS_CHAIN_LEN-1:0] r);
      logic [ABS_CHAIN_LEN-1:0] v;
      v = r & ~39'h7F_8002_0072;
      case (r[38:37])
         2'd0: v[POS_GND_EN] = 1'b1;
         2'd1: v[POS_BG_NEG] = 1'b1;
         default: v[POS_NEG_SEL +: NEG_SEL_W] = r[6:4] | 3'h1;
      endcase
      return v;
   endfunction : legal
   task automatic scan(input logic [ABS_CHAIN_LEN-1:0] vin, output logic [ABS_CHAIN_LEN-1:0] vout);
      @(posedge i_core_clk);
      o_capture_dr <= 1'b1;
      @(posedge i_core_clk);
      o_capture_dr <= 1'b0;
      o_shift_dr <= 1'b1;
      o_tdi <= vin[0];
      for (int i = 0; i < ABS_CHAIN_LEN; i++) begin
         @(negedge i_core_clk);
         vout[i] = i_tdo;
         @(posedge i_core_clk);
         // released data line shows the inverse of its last bit
         o_tdi <= (i < ABS_CHAIN_LEN - 1) ? vin[i + 1] : ~vin[i];
      end
      o_shift_dr <= 1'b0;
      o_update_dr <= 1'b1;
      @(posedge i_core_clk);
      o_update_dr <= 1'b0;
   endtask : scan
endmodule : abs_tester

// File: verif/testbench.sv
// self-checking bench for the converter boundary-scan control cells
`timescale 1ns/10ps
module testbench;
   import abs_pkg::*;
   localparam logic [ABS_CHAIN_LEN-1:0] M = ~(39'h1 << POS_COMP);
   logic clk, rst, cap, sh, upd, tdi, tdo, comp, wr, rd, en;
   logic [ABS_ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata, r32;
   logic [ABS_CHAIN_LEN-1:0] v;
   logic [ABS_CHAIN_LEN-1:0] q[$];
   wire logic [ABS_CHAIN_LEN-1:0] ov;
   // the capture cell has no control output, its slot is tied off and masked
   assign ov[POS_COMP] = 1'b0;
   int err_total, n_tests;
   int ks[5] = '{POS_HOLD, POS_COMPARATOR_PRECHARGE_N_N, POS_SUPPLY_REF, POS_CONV_PWR, POS_PASS_GATE};
   abs_tester tester_u (.i_core_clk(clk), .i_tdo(tdo), .o_capture_dr(cap), .o_shift_dr(sh),
      .o_update_dr(upd), .o_tdi(tdi));
   abs_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_capture_dr(cap), .i_shift_dr(sh),
      .i_update_dr(upd), .i_tdi(tdi), .o_tdo(tdo), .i_comparator_out(comp), .i_addr(addr),
      .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .o_sample_hold(ov[16]),
      .o_comparator_precharge_n(ov[2]), .o_neg_input_ground_enable(ov[17]),
      .o_neg_input_select(ov[6:4]), .o_gain_pass_gate_enable(ov[3]),
      .o_supply_reference_select(ov[0]), .o_settle_assist(ov[1]), .o_dac_code(ov[28:19]),
      .o_converter_power_enable(ov[30]), .o_gain_stage_power_enable(ov[29]),
      .o_input_mux_select(ov[14:7]), .o_bandgap_as_dac_reference(ov[15]),
      .o_bandgap_neg_enable(ov[31]), .o_gain_ten_enable(ov[36]), .o_gain_twenty_enable(ov[37]),
      .o_switch_cap_test_enable(ov[38]), .o_comparator_high_speed(ov[32]),
      .o_gain_clock(ov[34]), .o_gain_path_enable(ov[33]), .o_bypass_channels(ov[18]));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      test_done();
   end
   task automatic chk(input string nm, input logic [ABS_CHAIN_LEN-1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wreg(input logic [ABS_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [ABS_ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rreg
   task automatic do_scan(input logic [ABS_CHAIN_LEN-1:0] vin, input logic c);
      logic [ABS_CHAIN_LEN-1:0] got, e;
      @(posedge clk);
      comp <= c;
      repeat (3) @(posedge clk);
      e = q[$];
      e[POS_COMP] = c;
      tester_u.scan(vin, got);
      chk("scan_out", got, e);
      if (en) q.push_back(vin);
      repeat (2) @(negedge clk);
      chk("controls", ov & M, q[$] & M);
   endtask : do_scan
   initial begin
      rst = 1'b1;
      comp = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      en = 1'b1;
      err_total = 0;
      n_tests = 0;
      r32 = $urandom(45);
      q.push_back(ABS_IDLE);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("idle", ov & M, ABS_IDLE & M);
      foreach (ks[i]) do_scan(tester_u.legal(ABS_IDLE ^ (39'h1 << ks[i])), i[0]);
      for (int i = 0; i < 8; i++) do_scan(tester_u.legal(39'({$urandom, $urandom})), 1'($urandom));
      $display("test scan done");
      // ground added on odd codes to provoke the contention flag, scanned in directly
      for (int c = 0; c < 8; c++) begin
         v = q[$];
         v[POS_NEG_SEL +: NEG_SEL_W] = 3'(c);
         v[POS_GND_EN] = c[0];
         v[POS_BG_NEG] = 1'b0;
         do_scan(v, 1'(c >> 1));
         chk("neg_select", ov & M, v & M);
         rreg(ADDR_STATUS, r32);
         chk("status", 39'(r32), 39'({c[0], comp}));
      end
      $display("test register done");
      wreg(ADDR_CTRL, 32'h0);
      en = 1'b0;
      do_scan(tester_u.legal(ABS_IDLE), 1'b1);
      // the update window is read-only, a write must leave it untouched
      wreg(ADDR_UPD_LO, ~q[$][31:0]);
      rreg(ADDR_UPD_LO, r32);
      chk("upd_lo", 39'(r32), 39'(q[$][31:0]));
      rreg(ADDR_UPD_HI, r32);
      chk("upd_hi", 39'(r32), 39'(q[$][38:32]));
      rreg(ADDR_CTRL, r32);
      chk("scan_en", 39'(r32), 39'h0);
      rreg(8'h10, r32);
      chk("unmapped", 39'(r32), 39'h0);
      wreg(ADDR_CTRL, 32'h1);
      en = 1'b1;
      $display("test hold done");
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      q.push_back(ABS_IDLE);
      @(negedge clk);
      chk("reset", ov & M, ABS_IDLE & M);
      $display("test reset done");
      test_done();
   end
endmodule : testbench
